// file: logic/dram_host_map.svh
`ifndef DRAM_HOST_MAP_SVH
`define DRAM_HOST_MAP_SVH
`define CLK_PERIOD_PS      4000
`define ROW_ADDR_HI        15
`define ROW_ADDR_LO        8
`define COL_ADDR_HI        7
`define COL_ADDR_LO        0
`define ROW_COUNT          256
`define INIT_CYCLES        8
`define POWERUP_WAIT_NS    100000
`define POWERUP_CYCLES     ((`POWERUP_WAIT_NS * 1000) / `CLK_PERIOD_PS)
`define REFRESH_IVL_PS     15625000
`define REFRESH_IVL_CYCLES (`REFRESH_IVL_PS / `CLK_PERIOD_PS)
`define ROW_PRECH_NS       90
`define ROW_PRECH_CYC      (((`ROW_PRECH_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ROW_HOLD_NS        20
`define ROW_HOLD_CYC       (((`ROW_HOLD_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ROW_TO_COL_NS      30
`define ROW_TO_COL_CYC     (((`ROW_TO_COL_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ROW_ACCESS_NS      150
`define ROW_ACCESS_CYC     (((`ROW_ACCESS_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ROW_PULSE_NS       150
`define ROW_PULSE_CYC      (((`ROW_PULSE_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define COL_TO_WRITE_NS    110
`define COL_TO_WRITE_CYC   (((`COL_TO_WRITE_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define ROW_TO_WRITE_NS    185
`define ROW_TO_WRITE_CYC   (((`ROW_TO_WRITE_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WRITE_PULSE_NS     45
`define WRITE_PULSE_CYC    (((`WRITE_PULSE_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PAGE_PRECH_NS      35
`define PAGE_PRECH_CYC     (((`PAGE_PRECH_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define REF_COL_SETUP_NS   10
`define REF_COL_SETUP_CYC  (((`REF_COL_SETUP_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define OUT_OFF_NS         40
`define OUT_OFF_CYC        (((`OUT_OFF_NS * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`endif

// file: logic/dram_host_pkg.sv
`default_nettype none
package dram_host_pkg;
  typedef enum logic [9:0] {
    ST_POWERUP  = 10'h001,
    ST_IDLE     = 10'h002,
    ST_ROW      = 10'h004,
    ST_COL      = 10'h008,
    ST_DATA     = 10'h010,
    ST_WRITE    = 10'h020,
    ST_PAGE     = 10'h040,
    ST_RAS_HIGH = 10'h080,
    ST_CBR_COL  = 10'h100,
    ST_CBR_ROW  = 10'h200
  } host_state_t;
  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_RMW   = 2'h2
  } host_op_t;
endpackage : dram_host_pkg
`default_nettype wire

// file: logic/dram_refresh_timer.sv
`default_nettype none
`include "dram_host_map.svh"
module dram_refresh_timer #(
  parameter int unsigned INTERVAL = `REFRESH_IVL_CYCLES
) (
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  input  wire logic enable_i,
  input  wire logic taken_i,
  output logic      due_o
);
  logic [15:0] count;

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || !enable_i) begin
      count <= 16'h0000;
    end else if (count == 16'(INTERVAL - 1)) begin
      count <= 16'h0000;
    end else begin
      count <= count + 16'h0001;
    end
  end

  // A due flag set in the cycle of the taking refresh survives the clear.
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || !enable_i) begin
      due_o <= 1'b0;
    end else if (count == 16'(INTERVAL - 1)) begin
      due_o <= 1'b1;
    end else if (taken_i) begin
      due_o <= 1'b0;
    end
  end
endmodule : dram_refresh_timer
`default_nettype wire

// file: logic/dram_host.sv
// Overview of operation
// - Word address goes out as row half, then column half, on shared lines.
// - Column strobe may toggle with new columns while the row stays open.
// - Every one of 256 rows must be strobed within each 4 ms.
// - After power-up wait 100 us, then issue eight row cycles.
// - Pulse column strobe high for page precharge to start a new cycle.
// - With output enable tied low, read-modify-write is separate read and write.
// - Distributed refresh issues one row refresh every 15.625 us.
// - Burst refresh covers all 256 rows back to back within 4 ms; the code uses distributed refresh only.
// - Hidden refresh after write holds write low and enable high; the code issues no hidden refresh.
`default_nettype none
`include "dram_host_map.svh"
module dram_host
  import dram_host_pkg::*;
#(
  parameter int unsigned POWERUP_WAIT = `POWERUP_CYCLES,
  parameter int unsigned REFRESH_IVL  = `REFRESH_IVL_CYCLES
) (
  input  wire logic                sys_clk_i,
  input  wire logic                rstn_i,
  input  wire logic                req_valid_i,
  input  wire dram_host_pkg::host_op_t req_op_i,
  input  wire logic [15:0]         req_addr_i,
  input  wire logic [3:0]          req_wdata_i,
  input  wire logic                req_page_i,
  output logic                     req_ready_o,
  output logic                     rsp_valid_o,
  output logic [3:0]               rsp_rdata_o,
  output logic                     init_done_o,
  output logic                     row_strobe_n_o,
  output logic                     column_strobe_n_o,
  output logic                     write_strobe_n_o,
  output logic                     output_enable_n_o,
  output logic [7:0]               mux_address_o,
  input  wire logic [3:0]          data_i,
  output logic [3:0]               data_o,
  output logic                     data_oe_o
);
  import dram_host_pkg::*;

  host_state_t state;
  host_op_t    op;
  logic [15:0] wait_cnt;
  logic [15:0] addr;
  logic [3:0]  wdata;
  logic [3:0]  init_cnt;
  logic        refresh_due;
  logic        refresh_taken;
  logic        wait_done;
  logic        page_ok;

  assign wait_done     = (wait_cnt == 16'h0000);
  // Decided on the edge that enters the page state, while the requester holds its inputs.
  assign page_ok = req_valid_i && req_page_i && !refresh_due &&
                   (req_addr_i[`ROW_ADDR_HI:`ROW_ADDR_LO] == addr[`ROW_ADDR_HI:`ROW_ADDR_LO]);
  assign refresh_taken = (state == ST_CBR_COL) && wait_done;

  // Refresh pacing keeps all rows inside the refresh period.
  // Pacing is distributed, so a back-to-back burst is never owed.
  dram_refresh_timer #(
    .INTERVAL (REFRESH_IVL)
  ) u_refresh (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .enable_i  (init_done_o),
    .taken_i   (refresh_taken),
    .due_o     (refresh_due)
  );

  function automatic logic [15:0] cyc(input int unsigned n);
    cyc = 16'(n - 1);
  endfunction : cyc

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state             <= ST_POWERUP;
      wait_cnt          <= 16'h0000;
      init_cnt          <= 4'h0;
      init_done_o       <= 1'b0;
      op                <= OP_READ;
      addr              <= 16'h0000;
      wdata             <= 4'h0;
      req_ready_o       <= 1'b0;
      rsp_valid_o       <= 1'b0;
      rsp_rdata_o       <= 4'h0;
      row_strobe_n_o    <= 1'b1;
      column_strobe_n_o <= 1'b1;
      write_strobe_n_o  <= 1'b1;
      output_enable_n_o <= 1'b1;
      mux_address_o     <= 8'h00;
      data_o            <= 4'h0;
      data_oe_o         <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      req_ready_o <= 1'b0;
      if (!wait_done) begin
        wait_cnt <= wait_cnt - 16'h0001;
      end
      unique case (state)
        ST_POWERUP: begin
          if (wait_cnt == 16'h0000 && init_cnt == 4'h0 && !init_done_o) begin
            wait_cnt <= cyc(POWERUP_WAIT);
            init_cnt <= 4'h1;
          end else if (wait_done) begin
            state    <= ST_CBR_COL;
            wait_cnt <= cyc(`REF_COL_SETUP_CYC);
            column_strobe_n_o <= 1'b0;
          end
        end
        ST_IDLE: begin
          // A request met by ready is taken even if refresh fell due meanwhile.
          if (req_valid_i && req_ready_o) begin
            op             <= req_op_i;
            addr           <= req_addr_i;
            wdata          <= req_wdata_i;
            mux_address_o  <= req_addr_i[`ROW_ADDR_HI:`ROW_ADDR_LO];
            state          <= ST_ROW;
            wait_cnt       <= cyc(`ROW_HOLD_CYC);
            row_strobe_n_o <= 1'b0;
          end else if (refresh_due) begin
            // Periodic refresh always starts from idle, so no hidden refresh is issued.
            state             <= ST_CBR_COL;
            column_strobe_n_o <= 1'b0;
            wait_cnt          <= cyc(`REF_COL_SETUP_CYC);
          end else begin
            req_ready_o <= 1'b1;
          end
        end
        ST_ROW: begin
          if (wait_done) begin
            mux_address_o <= addr[`COL_ADDR_HI:`COL_ADDR_LO];
            if (op == OP_WRITE) begin
              write_strobe_n_o <= 1'b0;
              data_o           <= wdata;
              data_oe_o        <= 1'b1;
            end else begin
              output_enable_n_o <= 1'b0;
            end
            state    <= ST_COL;
            wait_cnt <= cyc(`ROW_TO_COL_CYC - `ROW_HOLD_CYC);
          end
        end
        ST_COL: begin
          if (wait_done) begin
            column_strobe_n_o <= 1'b0;
            state             <= ST_DATA;
            // Row-to-write time, longer than row or column access, covers both timing regimes.
            wait_cnt <= cyc(`ROW_TO_WRITE_CYC);
          end
        end
        ST_DATA: begin
          if (wait_done) begin
            if (op == OP_WRITE) begin
              write_strobe_n_o <= 1'b1;
              data_oe_o        <= 1'b0;
              state            <= ST_PAGE;
              wait_cnt         <= 16'h0000;
              req_ready_o      <= page_ok;
            end else begin
              rsp_rdata_o <= data_i;
              rsp_valid_o <= 1'b1;
              if (op == OP_RMW) begin
                // Enable is pulsed, never tied low, so one row cycle may read then write.
                output_enable_n_o <= 1'b1;
                state             <= ST_WRITE;
                wait_cnt          <= cyc(`OUT_OFF_CYC);
              end else begin
                output_enable_n_o <= 1'b1;
                state             <= ST_PAGE;
                wait_cnt          <= 16'h0000;
                req_ready_o       <= page_ok;
              end
            end
          end
        end
        ST_WRITE: begin
          if (wait_done && write_strobe_n_o) begin
            data_o           <= wdata;
            data_oe_o        <= 1'b1;
            write_strobe_n_o <= 1'b0;
            wait_cnt         <= cyc(`WRITE_PULSE_CYC);
          end else if (wait_done) begin
            write_strobe_n_o <= 1'b1;
            data_oe_o        <= 1'b0;
            state            <= ST_PAGE;
            req_ready_o      <= page_ok;
          end
        end
        ST_PAGE: begin
          column_strobe_n_o <= 1'b1;
          // Ready was raised on entry only for a same-row request, so taking here
          // meets the requester on its handshake edge and never takes it twice.
          if (req_ready_o) begin
            op       <= req_op_i;
            addr     <= req_addr_i;
            wdata    <= req_wdata_i;
            state    <= ST_ROW;
            wait_cnt <= cyc(`PAGE_PRECH_CYC);
          end else begin
            row_strobe_n_o <= 1'b1;
            state          <= ST_RAS_HIGH;
            wait_cnt       <= cyc(`ROW_PRECH_CYC);
          end
        end
        ST_RAS_HIGH: begin
          if (wait_done) begin
            state <= init_done_o ? ST_IDLE : ST_POWERUP;
          end
        end
        ST_CBR_COL: begin
          if (wait_done) begin
            row_strobe_n_o <= 1'b0;
            state          <= ST_CBR_ROW;
            wait_cnt       <= cyc(`ROW_PULSE_CYC);
          end
        end
        ST_CBR_ROW: begin
          if (wait_done) begin
            row_strobe_n_o    <= 1'b1;
            column_strobe_n_o <= 1'b1;
            state             <= ST_RAS_HIGH;
            wait_cnt          <= cyc(`ROW_PRECH_CYC);
            if (!init_done_o) begin
              if (init_cnt == 4'(`INIT_CYCLES)) begin
                init_done_o <= 1'b1;
              end
              init_cnt <= init_cnt + 4'h1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule : dram_host
`default_nettype wire

// file: testbench/dram_host_monitor.sv
`default_nettype none
module dram_host_monitor
  import dram_host_pkg::*;
#(
  parameter int unsigned POWERUP_WAIT = 20
) (
  input wire logic        sys_clk_i,
  input wire logic        rstn_i,
  input wire logic        req_valid_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [3:0]  req_wdata_i,
  input wire logic        req_ready_o,
  input wire logic        init_done_o,
  input wire logic        row_strobe_n_o,
  input wire logic        column_strobe_n_o,
  input wire logic        write_strobe_n_o,
  input wire logic        output_enable_n_o,
  input wire logic [7:0]  mux_address_o,
  input wire logic [3:0]  data_o,
  input wire logic        data_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] addr;
  logic [3:0]  wdata;
  logic [7:0]  cas_cnt;
  logic [7:0]  ras_cnt;
  logic [7:0]  falls;
  logic [31:0] up;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  always_ff @(posedge sys_clk_i) begin
    if (req_valid_i && req_ready_o) begin
      addr  <= req_addr_i;
      wdata <= req_wdata_i;
    end
  end
  // Counters saturate so that a long strobe-low stretch cannot wrap into a false failure.
  always_ff @(posedge sys_clk_i) begin
    cas_cnt <= column_strobe_n_o ? 8'h00 : cas_cnt + {7'h00, cas_cnt != 8'hff};
    ras_cnt <= row_strobe_n_o ? 8'h00 : ras_cnt + {7'h00, ras_cnt != 8'hff};
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      falls <= 8'h00;
      up    <= 32'h0;
    end else begin
      falls <= falls + {7'h00, $fell(row_strobe_n_o) && falls != 8'hff};
      up    <= up + {31'h0, up != 32'hffffffff};
    end
  end
  property p_init; $rose(init_done_o) |-> falls >= 8 && up >= POWERUP_WAIT; endproperty
  a_init: assert property (p_init) else $error("ready before wait and eight cycles");
  property p_prech; $rose(row_strobe_n_o) |-> row_strobe_n_o[*8]; endproperty
  a_prech: assert property (p_prech) else $error("row precharge too short");
  property p_page; $rose(column_strobe_n_o) && !row_strobe_n_o |-> column_strobe_n_o[*8]; endproperty
  a_page: assert property (p_page) else $error("column precharge too short");
  property p_row; $fell(row_strobe_n_o) && column_strobe_n_o |-> mux_address_o == addr[15:8];
  endproperty
  a_row: assert property (p_row) else $error("wrong row half");
  property p_col; $fell(column_strobe_n_o) && !row_strobe_n_o |-> mux_address_o == addr[7:0];
  endproperty
  a_col: assert property (p_col) else $error("wrong column half");
  property p_early; $fell(column_strobe_n_o) && !row_strobe_n_o && !write_strobe_n_o
    |-> data_oe_o && data_o == wdata; endproperty
  a_early: assert property (p_early) else $error("early write data missing");
  property p_late; $fell(write_strobe_n_o) && !column_strobe_n_o
    |-> cas_cnt >= 27 && ras_cnt >= 46 && data_oe_o && data_o == wdata; endproperty
  a_late: assert property (p_late) else $error("late write too soon or no data");
  property p_cbr; $fell(row_strobe_n_o) && !column_strobe_n_o |-> cas_cnt >= 2; endproperty
  a_cbr: assert property (p_cbr) else $error("column setup before row too short");
  property p_drive; data_oe_o |-> output_enable_n_o; endproperty
  a_drive: assert property (p_drive) else $error("data driven with enable low");
endmodule : dram_host_monitor
bind dram_host dram_host_monitor #(.POWERUP_WAIT(POWERUP_WAIT)) i_mon (.sys_clk_i, .rstn_i,
  .req_valid_i, .req_addr_i, .req_wdata_i, .req_ready_o, .init_done_o, .row_strobe_n_o,
  .column_strobe_n_o, .write_strobe_n_o, .output_enable_n_o, .mux_address_o, .data_o,
  .data_oe_o);
`default_nettype wire

// file: testbench/dram_cell_model.sv
`default_nettype none
module dram_cell_model #(
  parameter int unsigned ACC_NS = 75
) (
  input  wire logic       row_strobe_n_i,
  input  wire logic       column_strobe_n_i,
  input  wire logic       write_strobe_n_i,
  input  wire logic       output_enable_n_i,
  input  wire logic [7:0] mux_address_i,
  input  wire logic [3:0] data_i,
  output logic [3:0]      data_o,
  output logic            data_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] mem [0:65535];
  logic [7:0] row;
  logic [7:0] col;
  logic [7:0] ref_row = 8'h00;
  logic       early = 1'b0;
  logic       cbr = 1'b0;
  logic       cas_late = 1'b1;
  // Strobes are sampled 1 ns late so that pins changed at the same edge have settled.
  always @(negedge row_strobe_n_i) begin
    #1;
    cbr = !column_strobe_n_i;
    if (cbr) ref_row = ref_row + 8'h01;
    else row = mux_address_i;
  end
  always @(posedge row_strobe_n_i) cbr = 1'b0;
  always @(negedge column_strobe_n_i) begin
    #1;
    if (!row_strobe_n_i && !cbr) begin
      col = mux_address_i;
      early = !write_strobe_n_i;
      if (early) mem[{row, col}] = data_i;
      data_o = mem[{row, col}];
    end
  end
  always @(negedge write_strobe_n_i) begin
    #1;
    if (!column_strobe_n_i && !row_strobe_n_i && !cbr && !early) mem[{row, col}] = data_i;
  end
  always @(column_strobe_n_i) cas_late <= #(ACC_NS) column_strobe_n_i;
  assign data_oe_o = !column_strobe_n_i && !cas_late && !output_enable_n_i && !early
    && !cbr;
endmodule : dram_cell_model
`default_nettype wire

// file: testbench/dram_host_test.sv
`default_nettype none
module dram_host_test;
  import dram_host_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i, rstn_i = 1'b0, req_valid_i = 1'b0, req_page_i = 1'b0;
  host_op_t    req_op_i = OP_READ;
  logic [15:0] req_addr_i = 16'h0000;
  logic [3:0]  req_wdata_i = 4'h0;
  logic [3:0]  rsp_rdata_o, data_i, data_o, mq, last = 4'h0;
  logic [7:0]  mux_address_o;
  logic        req_ready_o, rsp_valid_o, init_done_o, row_strobe_n_o, column_strobe_n_o;
  logic        write_strobe_n_o, output_enable_n_o, data_oe_o, moe;
  logic [3:0]  shadow [logic [15:0]];
  logic [3:0]  expq [$];
  logic [15:0] a [6];
  int          n_mismatch = 0, checks = 0;
  // A released pin shows the inverse of its last level, never a lucky match.
  assign data_i = data_oe_o ? data_o : (moe ? mq : ~last);
  always @(posedge sys_clk_i) last <= data_i;
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  dram_host #(.POWERUP_WAIT(20), .REFRESH_IVL(200)) i_dut (.sys_clk_i, .rstn_i, .req_valid_i,
    .req_op_i, .req_addr_i, .req_wdata_i, .req_page_i, .req_ready_o, .rsp_valid_o,
    .rsp_rdata_o, .init_done_o, .row_strobe_n_o, .column_strobe_n_o, .write_strobe_n_o,
    .output_enable_n_o, .mux_address_o, .data_i, .data_o, .data_oe_o);
  dram_cell_model #(.ACC_NS(75)) i_mem (.row_strobe_n_i(row_strobe_n_o),
    .column_strobe_n_i(column_strobe_n_o), .write_strobe_n_i(write_strobe_n_o),
    .output_enable_n_i(output_enable_n_o), .mux_address_i(mux_address_o), .data_i(data_i),
    .data_o(mq), .data_oe_o(moe));
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic req(input host_op_t o, input logic [15:0] ad, input logic [3:0] d,
                     input logic p);
    int i;
    @(posedge sys_clk_i);
    req_valid_i <= 1'b1;
    req_op_i    <= o;
    req_addr_i  <= ad;
    req_wdata_i <= d;
    req_page_i  <= p;
    i = 0;
    do begin
      @(posedge sys_clk_i);
      i++;
    end while (req_ready_o !== 1'b1 && i < 2000);
    req_valid_i <= 1'b0;
    if (i >= 2000) begin
      n_mismatch++;
      print_verdict();
    end
    if (o != OP_WRITE) expq.push_back(shadow[ad]);
    if (o != OP_READ) shadow[ad] = d;
  endtask : req
  always @(posedge sys_clk_i) begin
    if (rsp_valid_o === 1'b1)
      check(rsp_rdata_o, expq.size() > 0 ? expq.pop_front() : 4'hx);
  end
  initial begin
    int i;
    logic [15:0] b;
    void'($urandom(29734));
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    for (i = 0; i < 1000 && init_done_o !== 1'b1; i++) @(posedge sys_clk_i);
    check({3'h0, init_done_o}, 4'h1);
    $display("test init done");
    for (i = 0; i < 6; i++) begin
      a[i] = 16'($urandom);
      req(OP_WRITE, a[i], 4'($urandom), 1'b0);
    end
    for (i = 0; i < 6; i++) req(OP_READ, a[i], 4'h0, 1'b0);
    $display("test write and read done");
    for (i = 0; i < 6; i++) begin
      req(OP_RMW, a[i], 4'($urandom), 1'b0);
      req(OP_READ, a[i], 4'h0, 1'b0);
    end
    $display("test read-modify-write done");
    b = 16'($urandom);
    for (i = 0; i < 4; i++) req(OP_WRITE, {b[15:8], 8'(i * 37)}, 4'(i + 5), 1'b1);
    for (i = 0; i < 4; i++) req(OP_READ, {b[15:8], 8'(i * 37)}, 4'h0, i != 3);
    $display("test page done");
    repeat (700) @(posedge sys_clk_i);
    for (i = 0; i < 6; i++) req(OP_READ, a[i], 4'h0, 1'b0);
    $display("test refresh done");
    for (i = 0; i < 300 && expq.size() > 0; i++) @(posedge sys_clk_i);
    check(4'(expq.size()), 4'h0);
    print_verdict();
  end
endmodule : dram_host_test
`default_nettype wire
